// [sim/conv_controller_model.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_controller_model #(
  parameter int unsigned HIGH_CYC = 10
) (
  // Clock
  input wire logic sys_clk,
  // Bench requests
  input wire logic conv_req,
  input wire logic pd_req,
  input wire logic strap_lvds,
  // Device inputs
  output var logic conv_trigger,
  output var logic power_down_req,
  output logic io_mode_lvds
);
  int unsigned hold_cnt = 0;
  initial conv_trigger = 1'b0;
  initial power_down_req = 1'b0;
  // Trigger held past the minimum high time
  always @(negedge sys_clk) begin
    if (conv_req)
      hold_cnt = HIGH_CYC;
    else if (hold_cnt != 0)
      hold_cnt = hold_cnt - 1;
    conv_trigger <= (hold_cnt != 0);
    power_down_req <= pd_req;
  end
  assign io_mode_lvds = strap_lvds;
endmodule // conv_controller_model
`default_nettype wire

// [sim/sampling_conversion_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sampling_conversion_control_test;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic conv_req = 1'b0;
  logic pd_req = 1'b0;
  logic strap = 1'b0;
  logic chip_select_n = 1'b1;
  logic [7:0] chan_enable = 8'hff;
  logic shift_clk_toggle = 1'b0;
  logic conv_trigger, power_down_req, io_mode_lvds, busy;
  logic fwd_clk, lvds_mode, powered_down, global_reset;
  logic [7:0] chan_hold;
  logic [31:0] seed = 32'h633c;
  int n_mismatch = 0;
  int total_checks = 0;
  int gr_cnt = 0;
  int gr_base;
  always #2 sys_clk = ~sys_clk;
  conv_controller_model i_conv_controller_model (.sys_clk(sys_clk),
    .conv_req(conv_req), .pd_req(pd_req), .strap_lvds(strap),
    .conv_trigger(conv_trigger), .power_down_req(power_down_req),
    .io_mode_lvds(io_mode_lvds));
  sampling_conversion_control i_sampling_conversion_control (
    .sys_clk(sys_clk), .reset_n(reset_n), .conv_trigger(conv_trigger),
    .power_down_req(power_down_req), .chip_select_n(chip_select_n),
    .io_mode_lvds(io_mode_lvds), .chan_enable(chan_enable),
    .shift_clk_toggle(shift_clk_toggle), .busy(busy),
    .chan_hold(chan_hold), .forwarded_shift_clock(fwd_clk),
    .lvds_mode(lvds_mode), .powered_down(powered_down),
    .global_reset(global_reset));
  function automatic logic [31:0] next_rand(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  always @(negedge sys_clk) begin
    seed <= next_rand(seed);
    shift_clk_toggle <= seed[3];
  end
  always @(posedge sys_clk)
    if (global_reset === 1'b1)
      gr_cnt++;
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_conv(input logic [7:0] en, input logic pd_mid);
    int n;
    int cyc;
    n = ($countones(en) == 0) ? 1 : $countones(en);
    chan_enable <= en;
    conv_req <= 1'b1;
    @(negedge sys_clk);
    conv_req <= 1'b0;
    cyc = 0;
    while (busy !== 1'b1 && cyc < 8) begin
      @(negedge sys_clk);
      cyc++;
    end
    if (cyc == 8) begin
      n_mismatch++;
      test_done();
    end
    check(chan_hold, 8'hff);
    cyc = 0;
    while (busy === 1'b1 && cyc < 3000) begin
      conv_req <= (cyc == 30);
      if (cyc == 50)
        pd_req <= pd_mid;
      @(negedge sys_clk);
      cyc++;
    end
    if (cyc == 3000) begin
      n_mismatch++;
      test_done();
    end
    if (!strap)
      check(fwd_clk, 1'b0);
    check(cyc >= n * conv_ctrl_pkg::CONV_MIN_CYC_PER_CH, 1'b1);
    check(cyc <= n * conv_ctrl_pkg::CONV_MAX_CYC_PER_CH, 1'b1);
    repeat (14) @(negedge sys_clk);
    check(busy, 1'b0);
    check(chan_hold, 8'h00);
    check(powered_down, pd_mid);
    $display("conversion of %h done", en);
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    check({busy, powered_down, global_reset}, 3'b000);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check(chan_hold, 8'h00);
    for (int i = 0; i < 4; i++) begin
      strap <= i[0];
      chip_select_n <= i[1];
      repeat (2) @(negedge sys_clk);
      check(lvds_mode, i[0]);
      do_conv(i == 0 ? 8'h00 : (i == 1 ? 8'hff : seed[7:0]), 1'b0);
    end
    gr_base = gr_cnt;
    pd_req <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check(powered_down, 1'b1);
    conv_req <= 1'b1;
    repeat (4) @(negedge sys_clk);
    conv_req <= 1'b0;
    check(busy, 1'b0);
    pd_req <= 1'b0;
    repeat (14) @(negedge sys_clk);
    do_conv(8'h01, 1'b0);
    pd_req <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check(gr_cnt - gr_base, 8'h00);
    pd_req <= 1'b0;
    repeat (3) @(negedge sys_clk);
    pd_req <= 1'b1;
    repeat (4) @(negedge sys_clk);
    check(gr_cnt - gr_base, 8'h01);
    pd_req <= 1'b0;
    repeat (3) @(negedge sys_clk);
    $display("power-down tests done");
    do_conv(seed[7:0], 1'b1);
    test_done();
  end
endmodule // sampling_conversion_control_test
`default_nettype wire

// [verilog/conv_ctrl_pkg.sv]
`default_nettype none

package conv_ctrl_pkg;

  // Clock period in picoseconds (250 MHz)
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Conversion time per enabled channel, in ns
  localparam int unsigned CONV_NOM_NS = 500;
  localparam int unsigned CONV_MIN_NS = 450;
  localparam int unsigned CONV_MAX_NS = 550;

  // Nominal cycles per enabled channel
  localparam int unsigned CONV_CYC_PER_CH =
    (CONV_NOM_NS * 1000) / CLK_PERIOD_PS;
  // Bounds in cycles: least rounds up, longest rounds down
  localparam int unsigned CONV_MIN_CYC_PER_CH =
    (CONV_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CONV_MAX_CYC_PER_CH =
    (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;

  localparam int unsigned NUM_CHAN = 8;
  localparam int unsigned CNT_W = 10;

  // Reset values
  localparam logic BUSY_RST = 1'b0;
  localparam logic SHIFT_CLK_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_PDN  = 3'b100
  } conv_state_type;

endpackage

`default_nettype wire

// [verilog/sampling_conversion_control.sv]
// Summary of operation
// - Trigger rising edge holds all channels and starts a conversion.
// - All channels sample at one shared instant.
// - Trigger acts whatever the chip-select state.
// - Busy rises at conversion start, falls when it finishes.
// - Power-down high enters power-down; triggers ignored meanwhile.
// - Power-down during conversion takes effect after the conversion ends.
// - Two power-down rises without a conversion cause a global reset.
// - I/O select strap picks differential or CMOS serial mode.
// - Conversion lasts 450 to 550 ns per enabled channel.
// - In CMOS mode forwarded clock is forced low as busy falls.
`timescale 1ns/1ps
`default_nettype none

module sampling_conversion_control #(
  parameter int unsigned NUM_CHAN = conv_ctrl_pkg::NUM_CHAN
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Controller requests
  input wire logic conv_trigger,
  input wire logic power_down_req,
  input wire logic chip_select_n,
  input wire logic io_mode_lvds,
  input wire logic [NUM_CHAN-1:0] chan_enable,
  // Serial unit clock toggle request
  input wire logic shift_clk_toggle,
  // Status
  output logic busy,
  output logic [NUM_CHAN-1:0] chan_hold,
  output logic forwarded_shift_clock,
  output logic lvds_mode,
  output logic powered_down,
  output logic global_reset
);

  localparam int unsigned CNT_W = conv_ctrl_pkg::CNT_W;

  conv_ctrl_pkg::conv_state_type state_q;
  logic conv_start;
  logic [conv_ctrl_pkg::CNT_W-1:0] chk_run_q;
  logic [3:0] chk_n_q;
  logic trig_q;
  logic pd_q;
  logic pd_pend_q;
  logic pd_armed_q;
  logic [conv_ctrl_pkg::CNT_W-1:0] cnt_q;
  logic [conv_ctrl_pkg::CNT_W-1:0] conv_len;
  logic [3:0] n_en;
  logic trig_rise;
  logic pd_rise;
  logic conv_done;
  logic soft_rst;

  assign trig_rise = conv_trigger & ~trig_q;
  assign pd_rise = power_down_req & ~pd_q;
  assign conv_done = (state_q == conv_ctrl_pkg::ST_CONV) && (cnt_q == '0);
  assign soft_rst = global_reset;
  assign conv_start = (state_q == conv_ctrl_pkg::ST_IDLE) && trig_rise &&
                      !power_down_req;

  // Count enabled channels, minimum one
  always_comb begin
    n_en = 4'h0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      n_en = n_en + {3'h0, chan_enable[i]};
    end
    if (n_en == 4'h0) begin
      n_en = 4'h1;
    end
  end

  assign conv_len = CNT_W'(n_en * conv_ctrl_pkg::CONV_CYC_PER_CH - 1);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      trig_q <= conv_trigger;
      pd_q <= power_down_req;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= conv_ctrl_pkg::ST_IDLE;
      cnt_q <= '0;
      pd_pend_q <= 1'b0;
    end else if (soft_rst) begin
      state_q <= conv_ctrl_pkg::ST_IDLE;
      cnt_q <= '0;
      pd_pend_q <= 1'b0;
    end else begin
      case (state_q)
        conv_ctrl_pkg::ST_IDLE: begin
          if (pd_rise || power_down_req) begin
            state_q <= conv_ctrl_pkg::ST_PDN;
          end else if (trig_rise) begin
            state_q <= conv_ctrl_pkg::ST_CONV;
            cnt_q <= conv_len;
          end
        end
        conv_ctrl_pkg::ST_CONV: begin
          if (pd_rise) begin
            pd_pend_q <= 1'b1;
          end
          if (cnt_q == '0) begin
            pd_pend_q <= 1'b0;
            state_q <= (pd_pend_q || pd_rise || power_down_req) ?
              conv_ctrl_pkg::ST_PDN : conv_ctrl_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        conv_ctrl_pkg::ST_PDN: begin
          if (!power_down_req) begin
            state_q <= conv_ctrl_pkg::ST_IDLE;
          end
        end
        default: state_q <= conv_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pd_armed_q <= 1'b0;
      global_reset <= 1'b0;
    end else begin
      global_reset <= 1'b0;
      // A rise during a conversion still arms; a new start, a soft reset or the rise that fires the reset disarms
      if (soft_rst || conv_start) begin
        pd_armed_q <= 1'b0;
      end else if (pd_rise) begin
        if (pd_armed_q) begin
          global_reset <= 1'b1;
          pd_armed_q <= 1'b0;
        end else begin
          pd_armed_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= conv_ctrl_pkg::BUSY_RST;
    end else if (soft_rst) begin
      busy <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
    end else if (conv_done || state_q != conv_ctrl_pkg::ST_CONV) begin
      busy <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_hold
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          chan_hold[g] <= 1'b0;
        end else if (soft_rst) begin
          chan_hold[g] <= 1'b0;
        end else if (conv_start) begin
          chan_hold[g] <= 1'b1;
        end else if (conv_done) begin
          chan_hold[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // clock forced low at end of conversion in CMOS mode only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      forwarded_shift_clock <= conv_ctrl_pkg::SHIFT_CLK_RST;
    end else if (conv_done && !lvds_mode) begin
      forwarded_shift_clock <= 1'b0;
    end else if (shift_clk_toggle && !chip_select_n) begin
      forwarded_shift_clock <= ~forwarded_shift_clock;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lvds_mode <= 1'b0;
    end else begin
      lvds_mode <= io_mode_lvds;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      powered_down <= 1'b0;
    end else begin
      powered_down <= (state_q == conv_ctrl_pkg::ST_PDN);
    end
  end

  // Busy run length, kept only for the span check
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_run_q <= '0;
      chk_n_q <= 4'h0;
    end else if (conv_start) begin
      chk_run_q <= '0;
      chk_n_q <= n_en;
    end else if (busy) begin
      chk_run_q <= chk_run_q + 1'b1;
    end
  end

  // Checks
  sequence s_start;
    conv_start;
  endsequence

  property p_busy_rise;
    @(posedge sys_clk) disable iff (!reset_n || soft_rst)
      s_start |=> busy && chan_hold == '1;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy not raised at conversion start");

  property p_busy_len;
    @(posedge sys_clk) disable iff (!reset_n || soft_rst)
      s_start and (n_en == 4'h1) |=> busy [*8] ##[1:200] !busy;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("single channel conversion length wrong");

  property p_busy_span;
    @(posedge sys_clk) disable iff (!reset_n || soft_rst)
      $fell(busy) && !$past(soft_rst) |->
        int'(chk_run_q) >= int'(chk_n_q) * 113 &&
        int'(chk_run_q) <= int'(chk_n_q) * 137;
  endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("busy span outside per-channel conversion bounds");

  property p_pd_ignore;
    @(posedge sys_clk) disable iff (!reset_n)
      state_q == conv_ctrl_pkg::ST_PDN |=> !busy;
  endproperty
  a_pd_ignore: assert property (p_pd_ignore)
    else $error("busy high while powered down");

  property p_pd_after;
    @(posedge sys_clk) disable iff (!reset_n || soft_rst)
      state_q == conv_ctrl_pkg::ST_CONV && pd_rise && cnt_q != '0
      |=> state_q == conv_ctrl_pkg::ST_CONV;
  endproperty
  a_pd_after: assert property (p_pd_after)
    else $error("power-down cut a conversion short");

  property p_sclk_low;
    @(posedge sys_clk) disable iff (!reset_n)
      conv_done && !lvds_mode |=> !forwarded_shift_clock;
  endproperty
  a_sclk_low: assert property (p_sclk_low)
    else $error("shift clock not low after busy fall");

  property p_hold_same;
    @(posedge sys_clk) disable iff (!reset_n)
      busy |-> chan_hold == '1;
  endproperty
  a_hold_same: assert property (p_hold_same)
    else $error("channels not held together");

  property p_pd_enter;
    @(posedge sys_clk) disable iff (!reset_n || soft_rst)
      state_q == conv_ctrl_pkg::ST_IDLE && power_down_req
      |=> ##1 powered_down;
  endproperty
  a_pd_enter: assert property (p_pd_enter)
    else $error("power-down not entered");

  property p_greset;
    @(posedge sys_clk) disable iff (!reset_n)
      global_reset |=> state_q == conv_ctrl_pkg::ST_IDLE && !busy;
  endproperty
  a_greset: assert property (p_greset)
    else $error("global reset did not clear state");

endmodule // sampling_conversion_control

`default_nettype wire
